// ---- src/bdm_gp_ram.sv ----
`timescale 1ns/10ps
module bdm_gp_ram
   import bdm_pkg::*;
(
   // Clock.
   input  wire logic pclk,
   // Access port.
   bdm_mem_if.ram    mem
);

   logic [DATA_W-1:0] store_q [GP_DEPTH];

   // Plain flip-flop storage; contents are volatile and left unset by reset.
   genvar g;
   generate
      for (g = 0; g < GP_DEPTH; g++)
      begin : g_entry
         always_ff @(posedge pclk)
         begin
            if (mem.we && (mem.idx == IDX_W'(g)))
            begin
               store_q[g] <= mem.wdata;
            end
         end
      end
   endgenerate

   assign mem.rdata = (int'(mem.idx) < GP_DEPTH) ? store_q[mem.idx] : RESET_BYTE;

endmodule : bdm_gp_ram

// ---- src/bdm_mem_if.sv ----
`timescale 1ns/10ps
interface bdm_mem_if;
   import bdm_pkg::*;

   logic [IDX_W-1:0]  idx;
   logic              we;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output idx, output we, output wdata, input rdata);
   modport ram  (input idx, input we, input wdata, output rdata);

endinterface : bdm_mem_if

// ---- src/bdm_pkg.sv ----
package bdm_pkg;

   localparam int          DATA_W       = 8;
   localparam int          LOC_W        = 8;
   localparam int          IDX_W        = 8;

   // APB map: paddr[11:10] picks the access kind, paddr[9:2] the data memory location.
   localparam int          REGION_HI    = 11;
   localparam int          REGION_LO    = 10;
   localparam int          LOC_HI       = 9;
   localparam int          LOC_LO       = 2;
   localparam logic [1:0]  REGION_BYTE  = 2'h0;
   localparam logic [1:0]  REGION_SET   = 2'h1;
   localparam logic [1:0]  REGION_CLR   = 2'h2;
   localparam logic [1:0]  ALIGN_OK     = 2'h0;
   localparam int          BITSEL_W     = 3;
   localparam int          ALIGN_HI     = 1;
   localparam int          ALIGN_LO     = 0;
   localparam int          SFR_IDX_W    = 6;

   // Data memory locations (register indices).
   localparam logic [7:0]  LOC_PORT_A   = 8'h00;
   localparam logic [7:0]  LOC_PTR_A    = 8'h01;
   localparam logic [7:0]  LOC_PORT_B   = 8'h02;
   localparam logic [7:0]  LOC_PTR_B    = 8'h03;
   localparam logic [7:0]  LOC_BANK_SEL = 8'h04;
   localparam int          SFR_COUNT    = 64;
   localparam int          SFR_FIRST_GEN = 5;
   localparam logic [7:0]  GP_BASE      = 8'h40;
   localparam logic [7:0]  BANK1_TOP    = 8'h4f;
   localparam logic [7:0]  GP0_DEPTH    = 8'hc0;
   localparam int          GP_DEPTH     = 208;

   // Assigned special locations; the rest read as zero.
   localparam logic [63:0] SFR_USED     = 64'h1f00_ffff_7c3f_6dff;
   // Read-only special locations; here they have no flops, read as zero and ignore writes.
   localparam logic [63:0] SFR_RO       = 64'h0000_0000_0000_0100;

   localparam int          BANK_BIT_POS = 0;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
   localparam logic [7:0]  BIT_ONE      = 8'h01;

   typedef enum logic [1:0] {
      BDM_OP_READ,
      BDM_OP_WRITE,
      BDM_OP_SET,
      BDM_OP_CLR
   } bdm_op_t;

endpackage : bdm_pkg

// ---- src/bdm_top.sv ----
// Register access over APB was decided locally.
`timescale 1ns/10ps
module bdm_top
   import bdm_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // System reset sources.
   input  wire logic        sys_reset_req,
   input  wire logic        wdt_pd_reset,
   // Bank selection state.
   output logic             bank_select_bit
);

   bdm_mem_if mif ();

   logic               rst_req_s1_q;
   logic               rst_req_s2_q;
   logic               wdt_pd_s1_q;
   logic               wdt_pd_s2_q;
   logic               pready_q;
   logic               pslverr_q;
   logic [31:0]        prdata_q;
   logic [LOC_W-1:0]   pointer_a_q;
   logic [LOC_W-1:0]   pointer_b_q;
   logic               bank_q;
   logic [DATA_W-1:0]  sfr_q [SFR_COUNT];

   logic [1:0]         region;
   logic [LOC_W-1:0]   loc;
   logic               bus_err;
   bdm_op_t            op;
   logic               indirect;
   logic [LOC_W-1:0]   tgt_loc;
   logic               tgt_bank;
   logic               null_port;
   logic               tgt_sfr;
   logic               tgt_gp_ok;
   logic [IDX_W-1:0]   gp_idx;
   logic [DATA_W-1:0]  cur_val;
   logic [DATA_W-1:0]  new_val;
   logic [DATA_W-1:0]  bit_mask;
   logic               access_start;
   logic               access_done;
   logic               do_store;
   logic               sfr_writable;
   logic               bank_clear;
   logic               hit_port_a;
   logic               hit_port_b;
   logic [DATA_W-1:0]  sfr_val;
   logic               wr_ptr_a;
   logic               wr_ptr_b;
   logic               wr_bank;

   // Reset request pins come from outside the clock domain.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_req_s1_q <= 1'b0;
         rst_req_s2_q <= 1'b0;
      end
      else
      begin
         rst_req_s1_q <= sys_reset_req;
         rst_req_s2_q <= rst_req_s1_q;
      end
   end

   // Same depth as the request path, so a watchdog reset and its request arrive on one edge.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdt_pd_s1_q <= 1'b0;
         wdt_pd_s2_q <= 1'b0;
      end
      else
      begin
         wdt_pd_s1_q <= wdt_pd_reset;
         wdt_pd_s2_q <= wdt_pd_s1_q;
      end
   end

   // A watchdog reset taken in power-down keeps the bank so a sleeping task resumes in place.
   assign bank_clear = rst_req_s2_q && !wdt_pd_s2_q;

   // Bus decode.
   assign region  = paddr[REGION_HI:REGION_LO];
   assign loc     = paddr[LOC_HI:LOC_LO];
   assign bus_err = (paddr[ALIGN_HI:ALIGN_LO] != ALIGN_OK) || (region > REGION_CLR);
   assign hit_port_a = (loc == LOC_PORT_A);
   assign hit_port_b = (loc == LOC_PORT_B);

   // Bit operations ignore pwrite, so a master may issue them in either direction.
   always_comb
   begin
      unique case (region)
         REGION_SET: op = BDM_OP_SET;
         REGION_CLR: op = BDM_OP_CLR;
         default:    op = pwrite ? BDM_OP_WRITE : BDM_OP_READ;
      endcase
   end

   // Address resolution: direct, or through one of the two pointer pairs.
   // Direct accesses never look at the bank, so bank 1 is reachable only through port B.
   always_comb
   begin
      indirect = 1'b0;
      tgt_loc  = loc;
      tgt_bank = 1'b0;
      if (hit_port_a)
      begin
         indirect = 1'b1;
         tgt_loc  = pointer_a_q;
         tgt_bank = 1'b0;
      end
      else if (hit_port_b)
      begin
         indirect = 1'b1;
         tgt_loc  = pointer_b_q;
         tgt_bank = bank_q;
      end
   end

   // A pointer that names a port itself reaches nothing.
   // Such a write is dropped rather than falling through to the special area.
   assign null_port = indirect && ((tgt_loc == LOC_PORT_A) || (tgt_loc == LOC_PORT_B));

   // The special area ignores the bank; only the general area is banked.
   assign tgt_sfr   = (tgt_loc < GP_BASE);
   assign tgt_gp_ok = !tgt_sfr && (!tgt_bank || (tgt_loc <= BANK1_TOP));
   // Bank 1 entries follow the bank 0 entries in one store, so one port serves both banks.
   assign gp_idx    = tgt_bank ? IDX_W'(GP0_DEPTH + (tgt_loc - GP_BASE))
                               : IDX_W'(tgt_loc - GP_BASE);

   // Special area value; the bank plays no part here, which is what mirrors it.
   always_comb
   begin
      unique case (tgt_loc)
         LOC_PTR_A:    sfr_val = pointer_a_q;
         LOC_PTR_B:    sfr_val = pointer_b_q;
         LOC_BANK_SEL: sfr_val = {{(DATA_W-1){1'b0}}, bank_q};
         default:      sfr_val = sfr_q[tgt_loc[SFR_IDX_W-1:0]];
      endcase
   end

   // Current value of the resolved location.
   always_comb
   begin
      cur_val = RESET_BYTE;
      if (null_port)
      begin
         cur_val = RESET_BYTE;
      end
      else if (tgt_sfr)
      begin
         cur_val = sfr_val;
      end
      else if (tgt_gp_ok)
      begin
         cur_val = mif.rdata;
      end
   end

   // New value for write and bit operations; a bit operation changes one bit only.
   assign bit_mask = BIT_ONE << pwdata[BITSEL_W-1:0];

   always_comb
   begin
      unique case (op)
         BDM_OP_WRITE: new_val = pwdata[DATA_W-1:0];
         BDM_OP_SET:   new_val = cur_val | bit_mask;
         BDM_OP_CLR:   new_val = cur_val & ~bit_mask;
         default:      new_val = cur_val;
      endcase
   end

   // One wait state: data is prepared in the first access cycle and pready rises in the next.
   assign access_start = psel && penable && !pready_q;
   assign access_done  = psel && penable && pready_q;
   assign do_store     = access_done && !bus_err && (op != BDM_OP_READ) && !null_port;

   // One strobe per stored special register, so a null port access can raise none of them.
   assign wr_ptr_a = do_store && (tgt_loc == LOC_PTR_A);
   assign wr_ptr_b = do_store && (tgt_loc == LOC_PTR_B);
   assign wr_bank  = do_store && (tgt_loc == LOC_BANK_SEL);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
      end
      else
      begin
         pready_q <= access_start;
      end
   end

   // The error pulse rides on the ready pulse and never stands alone.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr_q <= 1'b0;
      end
      else
      begin
         pslverr_q <= access_start && bus_err;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= RESET_WORD;
      end
      else if (access_start)
      begin
         // Captured before the store edge, so a bit operation returns the old value.
         prdata_q <= bus_err ? RESET_WORD : {{(32-DATA_W){1'b0}}, cur_val};
      end
   end

   // Pointer registers behave as ordinary storage, reachable directly or indirectly.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pointer_a_q <= RESET_BYTE;
      end
      else if (wr_ptr_a)
      begin
         pointer_a_q <= new_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pointer_b_q <= RESET_BYTE;
      end
      else if (wr_ptr_b)
      begin
         pointer_b_q <= new_val;
      end
   end

   // A system reset request beats a software write landing in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_q <= 1'b0;
      end
      else if (bank_clear)
      begin
         bank_q <= 1'b0;
      end
      else if (wr_bank)
      begin
         // Only bit 0 is stored; the upper bits have no flops and read as zero.
         bank_q <= new_val[BANK_BIT_POS];
      end
   end

   // Generic special registers: storage only where assigned and writable.
   // Read-only and unassigned entries have no flops, so a write to them finds nothing to change.
   assign sfr_writable = do_store && tgt_sfr;

   genvar s;
   generate
      for (s = 0; s < SFR_COUNT; s++)
      begin : g_sfr
         if ((s >= SFR_FIRST_GEN) && SFR_USED[s] && !SFR_RO[s])
         begin : g_rw
            always_ff @(posedge pclk or negedge presetn)
            begin
               if (!presetn)
               begin
                  sfr_q[s] <= RESET_BYTE;
               end
               else if (sfr_writable && (tgt_loc == LOC_W'(s)))
               begin
                  sfr_q[s] <= new_val;
               end
            end
         end
         else
         begin : g_fixed
            // Unassigned reads zero; read-only ignores writes here.
            assign sfr_q[s] = RESET_BYTE;
         end
      end
   endgenerate

   // General area storage.
   // The store has no reset: its content after power-up is undefined, as for any RAM.
   assign mif.idx   = gp_idx;
   assign mif.wdata = new_val;
   assign mif.we    = do_store && tgt_gp_ok;

   bdm_gp_ram u_gp_ram (
      .pclk (pclk),
      .mem  (mif.ram)
   );

   // Outputs.
   // Every output is a flop, so nothing combinational reaches the bus.
   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign bank_select_bit = bank_q;

endmodule : bdm_top

// ---- test/bdm_top_assertions.sv ----
`timescale 1ns/10ps
module bdm_checker
   import bdm_pkg::*;
(
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Resets and bank.
   input wire logic        sys_reset_req,
   input wire logic        wdt_pd_reset,
   input wire logic        bank_select_bit
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   AST_RDY_LAT: assert property (s_setup |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   AST_RDY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_ALIGN: assert property (s_done ##0 (paddr[1:0] != ALIGN_OK) |-> pslverr)
      else $error("misaligned access not refused");
   AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == RESET_WORD)
      else $error("error without ready or with data");
   AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   AST_BANK_RD: assert property (s_done ##0 (!pwrite && paddr == {REGION_BYTE, LOC_BANK_SEL, 2'h0}
      && $stable(bank_select_bit)) |-> prdata == {31'h0, bank_select_bit})
      else $error("bank register read wrong");
   AST_BANK_RST: assert property ($rose(presetn) |-> !bank_select_bit)
      else $error("bank not cleared by reset");
   AST_SYS_CLR: assert property ((sys_reset_req && !wdt_pd_reset) [*4] |-> !bank_select_bit)
      else $error("system reset did not clear bank");
   AST_WDT_HOLD: assert property (wdt_pd_reset [*4] ##0 !psel |=> $stable(bank_select_bit))
      else $error("bank changed during watchdog reset");
endmodule : bdm_checker

bind bdm_top bdm_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sys_reset_req(sys_reset_req), .wdt_pd_reset(wdt_pd_reset),
   .bank_select_bit(bank_select_bit));

// ---- test/test_banked_data_memory_indirect_access.sv ----
`timescale 1ns/10ps
module test_banked_data_memory_indirect_access;
   import bdm_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, bank_select_bit;
   logic        sys_reset_req = 0, wdt_pd_reset = 0;
   int          n_errors = 0, n_compared = 0;
   always #20 pclk = ~pclk;
   bdm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_reset_req(sys_reset_req), .wdt_pd_reset(wdt_pd_reset), .bank_select_bit(bank_select_bit));
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", s, exp, got);
      end
   endtask : chk
   // The request is held until pready is seen high, whatever the wait.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      // One idle edge keeps the next setup from driving psel again in this time step.
      @(posedge pclk);
   endtask : apb
   task automatic wb(input logic [7:0] l, input logic [7:0] d);
      apb({REGION_BYTE, l, 2'h0}, 1, {24'h0, d});
   endtask : wb
   task automatic rb(input logic [7:0] l);
      apb({REGION_BYTE, l, 2'h0}, 0, 0);
   endtask : rb
   task automatic t_direct;
      chk("bank", bank_select_bit, 0);
      wb(8'h40, 8'ha5);
      wb(8'hff, 8'h3c);
      apb(12'h101, 1, 32'hff);
      chk("err", er, 1);
      rb(8'h40);
      chk("gp40", rd, 32'ha5);
      rb(8'hff);
      chk("gpff", rd, 32'h3c);
      $display("t_direct done");
   endtask : t_direct
   task automatic t_indirect;
      wb(LOC_PTR_A, 8'h40);
      rb(LOC_PORT_A);
      chk("porta", rd, 32'ha5);
      wb(LOC_PORT_A, 8'h11);
      rb(8'h40);
      chk("gp40", rd, 32'h11);
      wb(LOC_BANK_SEL, 8'h01);
      wb(LOC_PTR_B, 8'h40);
      wb(LOC_PORT_B, 8'h77);
      rb(8'h40);
      chk("direct", rd, 32'h11);
      rb(LOC_PORT_A);
      chk("porta1", rd, 32'h11);
      rb(LOC_PORT_B);
      chk("portb1", rd, 32'h77);
      rb(LOC_PTR_B);
      chk("ptrb", rd, 32'h40);
      wb(LOC_BANK_SEL, 8'h00);
      rb(LOC_PORT_B);
      chk("portb0", rd, 32'h11);
      $display("t_indirect done");
   endtask : t_indirect
   task automatic t_null;
      wb(LOC_PTR_A, LOC_PORT_B);
      wb(LOC_PORT_A, 8'h55);
      rb(LOC_PORT_A);
      chk("nulla", rd, 0);
      wb(LOC_PTR_B, LOC_PORT_A);
      rb(LOC_PORT_B);
      chk("nullb", rd, 0);
      $display("t_null done");
   endtask : t_null
   task automatic t_sfr;
      wb(8'h09, 8'hff);
      rb(8'h09);
      chk("unused", rd, 0);
      wb(8'h08, 8'hff);
      rb(8'h08);
      chk("ro", rd, 0);
      wb(8'h05, 8'h96);
      wb(LOC_BANK_SEL, 8'h01);
      wb(LOC_PTR_B, 8'h05);
      rb(LOC_PORT_B);
      chk("mirror", rd, 32'h96);
      wb(LOC_BANK_SEL, 8'h00);
      $display("t_sfr done");
   endtask : t_sfr
   task automatic t_bits;
      wb(8'h42, 8'hf0);
      apb({REGION_SET, 8'h42, 2'h0}, 1, 3);
      chk("set", rd, 32'hf0);
      apb({REGION_CLR, 8'h42, 2'h0}, 1, 7);
      chk("clr", rd, 32'hf8);
      rb(8'h42);
      chk("bits", rd, 32'h78);
      $display("t_bits done");
   endtask : t_bits
   task automatic t_bank;
      wb(LOC_BANK_SEL, 8'hff);
      rb(LOC_BANK_SEL);
      chk("bankreg", rd, 1);
      wdt_pd_reset <= 1;
      sys_reset_req <= 1;
      repeat (6) @(posedge pclk);
      chk("wdt", bank_select_bit, 1);
      wdt_pd_reset <= 0;
      repeat (6) @(posedge pclk);
      chk("sys", bank_select_bit, 0);
      sys_reset_req <= 0;
      apb({2'h3, 8'h40, 2'h0}, 1, 0);
      chk("kind3", er, 1);
      wb(LOC_BANK_SEL, 8'h01);
      chk("bank1", bank_select_bit, 1);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk("rst", bank_select_bit, 0);
      $display("t_bank done");
   endtask : t_bank
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_direct();
      t_indirect();
      t_null();
      t_sfr();
      t_bits();
      t_bank();
      final_report();
   end
   // About 190 cycles are needed; a hang is cut off well beyond that.
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      final_report();
   end
endmodule : test_banked_data_memory_indirect_access
